// ===== design/refresh_master.sv
// Periodic DMA refresh bus master: arbitration, bus sequencer and row counter.
// Operation
// RQ1: Own oscillator ticks about every 30 us.
// RQ2: Disable setting suppresses requests and refresh cycles.
// RQ3: Request pulse sets request flop, asserts DMA request.
// RQ4: Processor grants after finishing its bus cycle.
// RQ5: Grant edge loads pending into bus-acquired flop.
// RQ6: Bus-acquired drives selection acknowledge.
// RQ7: Idle device passes grant on after 100 ns.
// RQ8: Mastership needs acquired, delayed grant, idle sync, reply.
// RQ9: Mastership asserts refresh line for whole transaction.
// RQ10: Mastership drives six-bit row onto lines 1-6.
// RQ11: Sequencer steps on 220 ns sequencing clock.
// RQ12: Master-sync set, then state A with sync strobe.
// RQ13: State B asserts read strobe until reply.
// RQ14: Memory replies and drops reply after read strobe.
// RQ15: Reply captured; A clears; B held while reply.
// RQ16: Reply flop clears, then B clears ending sync.
// RQ17: End clears acquired and mastership, then master-sync.
// RQ18: Row counter increments when captured reply falls.
// RQ19: Done clears only when tick goes passive.
// RQ20: Power-ok low initialises all flops but done.
// RQ21: One transaction lasts about 1.2 us.
// RQ22: All 64 rows refreshed within 2 ms.
// RQ23: Bus initialise is ignored entirely.
// RQ24: Refresh holds top DMA priority, no bursts.
// RQ25: Processor's own refresh cycles are disabled.
// RQ26: Done set at completion blocks further requests.
`timescale 1ns/100ps
`default_nettype none
`include "refresh_params.svh"
module refresh_master
  import refresh_pkg::*;
#(
  parameter int TICK_CYC = `TICK_CYCLES,
  parameter int SEQ_CYC = `SEQ_CYCLES,
  parameter int GRANT_CYC = `GRANT_DELAY_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_refresh_disable_setting,
  input wire logic i_grant_chain_in_n,
  input wire logic i_bus_addr_strobe_n,
  input wire logic i_bus_slave_reply_n,
  output logic o_bus_dma_request_n,
  output logic o_grant_chain_out_n,
  output logic o_bus_select_ack_n,
  output logic o_bus_refresh_n,
  output logic o_bus_addr_strobe_n,
  output logic o_bus_read_strobe_n,
  output logic [15:0] o_muxed_addr_data_lines,
  output logic [15:0] o_muxed_addr_data_oe
);
  localparam int ROW_W = `ROW_BITS;
  // Sixty-four rows at one per tick must fit in the refresh limit.
  localparam longint SWEEP_NS = longint'(`ROW_COUNT) * longint'(TICK_CYC) *
    longint'(`CLK_PERIOD_NS); // [RQ22]
  generate
    if (GRANT_CYC < 1 || GRANT_CYC > 7 || SWEEP_NS > longint'(`REFRESH_LIMIT_NS)) begin : g_bad
      $error("refresh_master: parameter values cannot be served");
    end
  endgenerate

  refresh_timing_if tim ();
  refresh_timebase #(
    .TICK_CYC(TICK_CYC),
    .SEQ_CYC(SEQ_CYC)
  ) u_timebase (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .tim(tim)
  );

  function automatic logic in_state(input seq_state_t s, input logic [5:0] mask);
    return (s & mask) != 6'h00;
  endfunction : in_state

  wire logic grant_in = !i_grant_chain_in_n;
  wire logic reply_in = !i_bus_slave_reply_n;
  wire logic en = tim.seq_en;

  // Arbitration group.
  logic tick_q, tick_d;
  logic request_flop_q, request_flop_d;
  logic acquired_q, acquired_d;
  logic grant_q, grant_d;
  logic [2:0] gcnt_q, gcnt_d;
  logic delayed_grant_q, delayed_grant_d;
  logic master_q, master_d;
  logic req_pulse, release_clear;

  // Sequencer group.
  seq_state_t state_q, state_d;
  logic master_sync_q, master_sync_d;
  logic reply_q, reply_d;
  logic [ROW_W-1:0] row_q, row_d;

  // Done flop: outside power-ok initialisation on purpose.
  logic done_q, done_d;

  // Output group.
  logic req_n_q, gnt_out_n_q, sack_n_q, ref_n_q, sync_n_q, din_n_q;
  logic [15:0] dal_q, dal_oe_q;

  always_comb begin
    tick_d = tim.refresh_tick;
    req_pulse = tim.refresh_tick && !tick_q && !i_refresh_disable_setting && !done_q; // [RQ2]
    release_clear = (state_q == S_END);
    request_flop_d = request_flop_q;
    if (req_pulse) begin
      request_flop_d = 1'b1; // [RQ3]
    end else if (acquired_q) begin
      request_flop_d = 1'b0; // [RQ5]
    end
    grant_d = grant_in;
    acquired_d = acquired_q;
    if (release_clear) begin
      acquired_d = 1'b0; // [RQ17]
    end else if (grant_in && !grant_q) begin
      acquired_d = request_flop_q; // [RQ5]
    end
    gcnt_d = 3'h0;
    if (grant_in) begin
      gcnt_d = (gcnt_q == 3'(GRANT_CYC)) ? gcnt_q : gcnt_q + 3'h1;
    end
    delayed_grant_d = grant_in && (gcnt_d == 3'(GRANT_CYC)); // [RQ7]
    master_d = master_q;
    if (release_clear) begin
      master_d = 1'b0; // [RQ17]
    end else if (acquired_q && delayed_grant_q && i_bus_addr_strobe_n && !reply_in) begin
      master_d = 1'b1; // [RQ8]
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin // [RQ20] [RQ23]
      tick_q <= 1'b0;
      request_flop_q <= 1'b0;
      acquired_q <= 1'b0;
      grant_q <= 1'b0;
      gcnt_q <= 3'h0;
      delayed_grant_q <= 1'b0;
      master_q <= 1'b0;
    end else begin
      tick_q <= tick_d;
      request_flop_q <= request_flop_d;
      acquired_q <= acquired_d;
      grant_q <= grant_d;
      gcnt_q <= gcnt_d;
      delayed_grant_q <= delayed_grant_d;
      master_q <= master_d;
    end
  end

  // The sequencer moves only on sequencing-clock enables.
  always_comb begin
    state_d = state_q;
    master_sync_d = master_sync_q;
    reply_d = reply_q;
    row_d = row_q;
    if (en) begin // [RQ11] [RQ21]
      master_sync_d = master_q; // [RQ12] [RQ17]
      reply_d = reply_in && in_state(state_q, S_READ | S_HOLD);
      unique case (state_q)
        S_IDLE: if (master_q) state_d = S_SYNC;
        S_SYNC: state_d = master_sync_q ? S_ADDR : S_IDLE; // [RQ12]
        S_ADDR: state_d = S_READ; // [RQ13]
        S_READ: if (reply_q) state_d = S_HOLD; // [RQ15]
        S_HOLD: if (!reply_q) state_d = S_END; // [RQ16]
        S_END: state_d = S_IDLE;
      endcase
      if (reply_q && !reply_d) begin
        row_d = row_q + ROW_W'(1); // [RQ18]
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= S_IDLE;
      master_sync_q <= 1'b0;
      reply_q <= 1'b0;
      row_q <= `ROW_RESET;
    end else begin
      state_q <= state_d;
      master_sync_q <= master_sync_d;
      reply_q <= reply_d;
      row_q <= row_d;
    end
  end

  // Cleared while the tick is low, so after power-up it settles before the first tick.
  always_comb begin
    done_d = done_q;
    if (!tim.refresh_tick) begin
      done_d = 1'b0; // [RQ19]
    end else if (release_clear) begin
      done_d = 1'b1; // [RQ26]
    end
  end

  always_ff @(posedge i_clk_sys) begin
    done_q <= done_d;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_n_q <= 1'b1;
      gnt_out_n_q <= 1'b1;
      sack_n_q <= 1'b1;
      ref_n_q <= 1'b1;
      sync_n_q <= 1'b1;
      din_n_q <= 1'b1;
      dal_q <= 16'h0000;
      dal_oe_q <= 16'h0000;
    end else begin
      req_n_q <= !request_flop_d; // [RQ3]
      gnt_out_n_q <= !(delayed_grant_d && !acquired_d); // [RQ7]
      sack_n_q <= !acquired_d; // [RQ6]
      ref_n_q <= !master_d; // [RQ9]
      sync_n_q <= !(master_d && in_state(state_d, S_ADDR | S_READ | S_HOLD)); // [RQ12]
      din_n_q <= !in_state(state_d, S_READ); // [RQ13]
      dal_q <= 16'(row_d) << `ROW_LSB; // [RQ10]
      dal_oe_q <= master_d ? (16'(`ROW_COUNT - 1) << `ROW_LSB) : 16'h0000;
    end
  end

  assign o_bus_dma_request_n = req_n_q;
  assign o_grant_chain_out_n = gnt_out_n_q;
  assign o_bus_select_ack_n = sack_n_q;
  assign o_bus_refresh_n = ref_n_q;
  assign o_bus_addr_strobe_n = sync_n_q;
  assign o_bus_read_strobe_n = din_n_q;
  assign o_muxed_addr_data_lines = dal_q;
  assign o_muxed_addr_data_oe = dal_oe_q;

  // Checks.
  property p_req_sets;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      req_pulse |=> !o_bus_dma_request_n;
  endproperty
  a_req_sets: assert property (p_req_sets) else $error("request not raised"); // [RQ3]

  property p_disable_blocks;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      i_refresh_disable_setting |-> !req_pulse;
  endproperty
  a_disable_blocks: assert property (p_disable_blocks) else $error("request while disabled"); // [RQ2]

  property p_sack_follows;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      acquired_q |-> ##1 (!o_bus_select_ack_n || $past(release_clear));
  endproperty
  a_sack_follows: assert property (p_sack_follows) else $error("ack missing"); // [RQ6]

  property p_no_pass_when_mine;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      acquired_q |-> o_grant_chain_out_n;
  endproperty
  a_no_pass_when_mine: assert property (p_no_pass_when_mine) else $error("grant leaked"); // [RQ5]

  property p_grant_delay;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      !grant_in ##1 (grant_in && !acquired_q && !request_flop_q)[*5] |=> !o_grant_chain_out_n;
  endproperty
  a_grant_delay: assert property (p_grant_delay) else $error("grant not passed"); // [RQ7]

  property p_grant_not_early;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(grant_in) |-> o_grant_chain_out_n [*3];
  endproperty
  a_grant_not_early: assert property (p_grant_not_early) else $error("grant passed early"); // [RQ7]

  property p_ref_with_master;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      master_q |-> ##1 (!o_bus_refresh_n || $past(release_clear));
  endproperty
  a_ref_with_master: assert property (p_ref_with_master) else $error("refresh line off"); // [RQ9]

  property p_dal_driven;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      !o_bus_refresh_n |-> (o_muxed_addr_data_oe == 16'h007E);
  endproperty
  a_dal_driven: assert property (p_dal_driven) else $error("row not driven"); // [RQ10]

  property p_din_needs_sync;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      !o_bus_read_strobe_n |-> !o_bus_addr_strobe_n;
  endproperty
  a_din_needs_sync: assert property (p_din_needs_sync) else $error("read without sync"); // [RQ13]

  property p_row_step;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (en && reply_q && !reply_d) |=> (row_q == $past(row_q) + 6'h01);
  endproperty
  a_row_step: assert property (p_row_step) else $error("row not stepped"); // [RQ18]

  property p_one_per_tick;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      done_q && tim.refresh_tick |-> !req_pulse;
  endproperty
  a_one_per_tick: assert property (p_one_per_tick) else $error("second request in tick"); // [RQ26]

  property p_hold_until_reply;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (state_q == S_READ && !reply_q) |=> (state_q == S_READ || state_q == S_HOLD);
  endproperty
  a_hold_until_reply: assert property (p_hold_until_reply) else $error("left read early"); // [RQ15]

  c_request: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) req_pulse);
  c_pass: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) !o_grant_chain_out_n);
  c_done: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) $rose(state_q == S_END));
endmodule : refresh_master
`default_nettype wire

// ===== design/refresh_params.svh
// Timing counts, widths and reset values of the refresh bus master.
`ifndef REFRESH_PARAMS_SVH
`define REFRESH_PARAMS_SVH
`define CLK_PERIOD_NS 25
`define TICK_PERIOD_NS 30000
`define TICK_CYCLES ((`TICK_PERIOD_NS) / (`CLK_PERIOD_NS))
`define GRANT_DELAY_NS 100
`define GRANT_DELAY_CYCLES ((`GRANT_DELAY_NS + `CLK_PERIOD_NS - 1) / (`CLK_PERIOD_NS))
`define SEQ_PERIOD_NS 220
`define SEQ_CYCLES ((`SEQ_PERIOD_NS + `CLK_PERIOD_NS - 1) / (`CLK_PERIOD_NS))
`define XFER_NS 1200
`define ROW_BITS 6
`define ROW_COUNT 64
`define ROW_LSB 1
`define ROW_RESET 6'h00
`define REFRESH_LIMIT_NS 2000000
`endif

// ===== design/refresh_pkg.sv
// Types shared by the refresh bus master modules.
package refresh_pkg;
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_SYNC = 6'h02,
    S_ADDR = 6'h04,
    S_READ = 6'h08,
    S_HOLD = 6'h10,
    S_END = 6'h20
  } seq_state_t;
endpackage : refresh_pkg

// ===== design/refresh_timebase.sv
// Free-running refresh tick oscillator and sequencing clock divider.
`timescale 1ns/100ps
`default_nettype none
`include "refresh_params.svh"
module refresh_timebase #(
  parameter int TICK_CYC = `TICK_CYCLES,
  parameter int SEQ_CYC = `SEQ_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  refresh_timing_if.src tim
);
  generate
    if (TICK_CYC < 2 * SEQ_CYC || SEQ_CYC < 2 || TICK_CYC > 65536 || SEQ_CYC > 256) begin : g_bad
      $error("refresh_timebase: tick period too short for the sequencer");
    end
  endgenerate

  logic [15:0] tick_cnt_q, tick_cnt_d;
  logic [7:0] seq_cnt_q, seq_cnt_d;
  logic tick_q, tick_d;
  logic en_q, en_d;

  // The tick is a square wave; its rising edge starts one request.
  always_comb begin
    tick_cnt_d = (tick_cnt_q == 16'(TICK_CYC - 1)) ? 16'h0000 : tick_cnt_q + 16'h0001; // [RQ1]
    tick_d = (tick_cnt_d >= 16'(TICK_CYC / 2));
    seq_cnt_d = (seq_cnt_q == 8'(SEQ_CYC - 1)) ? 8'h00 : seq_cnt_q + 8'h01; // [RQ11]
    en_d = (seq_cnt_q == 8'(SEQ_CYC - 1));
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt_q <= 16'h0000;
      seq_cnt_q <= 8'h00;
      tick_q <= 1'b0;
      en_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      seq_cnt_q <= seq_cnt_d;
      tick_q <= tick_d;
      en_q <= en_d;
    end
  end

  assign tim.refresh_tick = tick_q;
  assign tim.seq_en = en_q;
endmodule : refresh_timebase
`default_nettype wire

// ===== design/refresh_timing_if.sv
// Carrier for the refresh tick level and the sequencing enable pulse.
`timescale 1ns/100ps
`default_nettype none
interface refresh_timing_if;
  logic refresh_tick;
  logic seq_en;
  modport src (output refresh_tick, output seq_en);
  modport snk (input refresh_tick, input seq_en);
endinterface : refresh_timing_if
`default_nettype wire

// ===== dv/dma_refresh_bus_master_tb_top.sv
// Self-checking bench of the refresh bus master with arbiter and memory model.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("Error at %0t ns: got %h expected %h", $time, (a), (b)); end end
module dma_refresh_bus_master_tb_top;
  localparam int TICK = 60;
  localparam int SEQ = 3;
  logic clk, rst_n, dis, bgrant_n, pgrant_n, reply_n;
  logic [1:0] dly;
  logic req_n, gout_n, ack_n, ref_n, as_n, rd_n;
  logic [15:0] lines, oe;
  logic ref_p, rd_p, rep_p, req_p;
  logic [5:0] exp_row;
  logic [31:0] rnd;
  int num_errors, checks_done, trans_cnt, req_cnt, cyc, t1, t65, n;

  refresh_master #(.TICK_CYC(TICK), .SEQ_CYC(SEQ)) refresh_master_inst (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_refresh_disable_setting(dis),
    .i_grant_chain_in_n(pgrant_n & bgrant_n), .i_bus_addr_strobe_n(as_n),
    .i_bus_slave_reply_n(reply_n), .o_bus_dma_request_n(req_n),
    .o_grant_chain_out_n(gout_n), .o_bus_select_ack_n(ack_n), .o_bus_refresh_n(ref_n),
    .o_bus_addr_strobe_n(as_n), .o_bus_read_strobe_n(rd_n),
    .o_muxed_addr_data_lines(lines), .o_muxed_addr_data_oe(oe));

  refresh_partner refresh_partner_inst (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_dly(dly), .i_dma_request_n(req_n),
    .i_select_ack_n(ack_n), .i_read_strobe_n(rd_n), .i_refresh_n(ref_n),
    .o_grant_n(pgrant_n), .o_reply_n(reply_n));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic wait_trans(input int want);
    int k;
    k = 0;
    while (trans_cnt < want && k < 100 * TICK) begin
      @(negedge clk);
      k++;
    end
    `CHK(trans_cnt >= want, 1'b1)
  endtask : wait_trans

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Edge monitor of the bus side, sampled where outputs have settled.
  always @(negedge clk) begin
    rnd = xs(rnd);
    dly <= rnd[1:0];
    cyc++;
    if (ref_p === 1'b1 && ref_n === 1'b0) begin
      `CHK(oe, 16'h007E)
      `CHK(lines, {9'h000, exp_row, 1'b0})
      `CHK(ack_n, 1'b0)
    end
    if (ref_p === 1'b0 && ref_n === 1'b1) begin
      `CHK({as_n, rd_n, req_n}, 3'h7)
      trans_cnt++;
      exp_row = exp_row + 6'h01;
      if (trans_cnt == 1) t1 = cyc;
      if (trans_cnt == 65) t65 = cyc;
    end
    if (rd_p === 1'b1 && rd_n === 1'b0) begin
      `CHK({as_n, ref_n}, 2'h0)
    end
    if (rep_p === 1'b1 && reply_n === 1'b0) begin
      `CHK(rd_n, 1'b0)
    end
    if (req_p === 1'b1 && req_n === 1'b0) req_cnt++;
    ref_p = ref_n;
    rd_p = rd_n;
    rep_p = reply_n;
    req_p = req_n;
  end

  initial begin
    repeat (12000) @(posedge clk);
    num_errors++;
    results();
  end

  initial begin
    rst_n = 1'b0;
    dis = 1'b0;
    bgrant_n = 1'b1;
    dly = 2'h0;
    rnd = 32'h00000005;
    exp_row = 6'h00;
    {ref_p, rd_p, rep_p, req_p} = 4'hF;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    wait_trans(70);
    `CHK(req_cnt, trans_cnt)
    `CHK((t65 - t1 > 63 * TICK) && (t65 - t1 < 65 * TICK), 1'b1)
    n = trans_cnt;
    while (trans_cnt == n) @(negedge clk);
    dis = 1'b1;
    n = req_cnt;
    repeat (4 * TICK) @(negedge clk);
    `CHK(req_cnt, n)
    bgrant_n = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(gout_n, 1'b1)
    repeat (4) @(negedge clk);
    `CHK({gout_n, ack_n}, 2'h1)
    bgrant_n = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(gout_n, 1'b1)
    dis = 1'b0;
    n = 0;
    while (req_n !== 1'b0 && n < 2 * TICK) begin
      @(negedge clk);
      n++;
    end
    rst_n = 1'b0;
    @(negedge clk);
    `CHK({req_n, ack_n, ref_n, as_n, rd_n, gout_n}, 6'h3F)
    `CHK(oe, 16'h0000)
    rst_n = 1'b1;
    exp_row = 6'h00;
    wait_trans(trans_cnt + 3);
    results();
  end
endmodule : dma_refresh_bus_master_tb_top
`default_nettype wire

// ===== dv/refresh_partner.sv
// Behavioural processor arbiter and refresh memory facing the refresh master.
`timescale 1ns/100ps
`default_nettype none
module refresh_partner (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [1:0] i_dly,
  input wire logic i_dma_request_n,
  input wire logic i_select_ack_n,
  input wire logic i_read_strobe_n,
  input wire logic i_refresh_n,
  output logic o_grant_n,
  output logic o_reply_n
);
  int gcnt;
  int rcnt;
  // The refresh master is the only DMA master and the processor runs no refresh of its own.
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_grant_n <= 1'b1;
      o_reply_n <= 1'b1;
      gcnt <= 0;
      rcnt <= 0;
    end else begin
      // Grant stays up until the master drives the refresh line, so its delayed grant can mature.
      if (!i_select_ack_n && !i_refresh_n) begin
        o_grant_n <= 1'b1;
        gcnt <= 0;
      end else if (!i_dma_request_n) begin
        if (gcnt >= i_dly) o_grant_n <= 1'b0;
        else gcnt <= gcnt + 1;
      end
      // Reply follows the refresh read strobe both ways after a random wait.
      if ((!i_read_strobe_n && !i_refresh_n) != !o_reply_n) begin
        if (rcnt >= i_dly) begin
          o_reply_n <= ~o_reply_n;
          rcnt <= 0;
        end else rcnt <= rcnt + 1;
      end else rcnt <= 0;
    end
  end
endmodule : refresh_partner
`default_nettype wire
